// ### i2c_host_model.sv
// Purpose: two-wire host that configures the regulator register bank
// Assumes: sys_clk far faster than the serial clock; sda has a pull-up
// Notes: all line changes land just after a sys_clk edge
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
  input wire logic sys_clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int PH = 5;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk

  // one clock pulse: scl low >= 4 cycles, data set >= 2 cycles before scl rises
  task automatic put_bit(input logic b, output logic seen);
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= !b;
    wait_clk(PH);
    scl <= 1'b1;
    wait_clk(2);
    seen = sda;
    wait_clk(PH - 2);
  endtask : put_bit

  task automatic start_cond(input logic repeated);
    if (repeated) begin
      scl <= 1'b0;
      wait_clk(2);
      sda_low <= 1'b0;
      wait_clk(PH);
      scl <= 1'b1;
      wait_clk(PH);
    end
    sda_low <= 1'b1;
    wait_clk(PH);
  endtask : start_cond

  task automatic stop_cond;
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= 1'b1;
    wait_clk(PH);
    scl <= 1'b1;
    wait_clk(PH);
    sda_low <= 1'b0;
    wait_clk(PH);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
    put_bit(last, s);
  endtask : recv_byte

  // ok is the and of every acknowledge seen in the transfer
  task automatic write_regs(input logic [7:0] dev, input logic [7:0] sub, input int n,
                            input logic [7:0] d [11], output logic ok);
    logic a;
    start_cond(1'b0);
    send_byte(dev, a);
    ok = a;
    send_byte(sub, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      send_byte(d[i], a);
      ok &= a;
    end
    stop_cond;
  endtask : write_regs

  task automatic read_regs(input logic [7:0] dev, input logic [7:0] sub, input int n,
                           output logic [7:0] d [11], output logic ok);
    logic a;
    logic [7:0] v;
    start_cond(1'b0);
    send_byte(dev, a);
    ok = a;
    send_byte(sub, a);
    ok &= a;
    start_cond(1'b1);
    send_byte(dev | 8'h01, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      recv_byte(i == n - 1, v);
      d[i] = v;
    end
    stop_cond;
  endtask : read_regs
endmodule : i2c_host_model
`default_nettype wire

// ### reg_store.sv
// Purpose: byte register bank with registered read data
// Assumes: synchronous active-high reset loads factory defaults
// Notes: unused bits are masked on write so they read as zero
`timescale 1ns/100ps
`default_nettype none
module reg_store #(
  parameter int NUM_REGS = regulator_cfg_pkg::NUM_REGS
) (
  input wire logic sys_clk,
  input wire logic rst,
  regfile_if.store rf
);

  logic [NUM_REGS-1:0][7:0] regs;
  logic [NUM_REGS-1:0][7:0] next_regs;
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  if (NUM_REGS != regulator_cfg_pkg::NUM_REGS) begin : g_chk
    $error("reg_store: register count must match the map");
  end

  always_comb begin
    next_regs = regs;
    next_rdata = 8'h00;
    if (rf.wr_en && rf.addr < 8'(NUM_REGS)) begin
      next_regs[rf.addr] = rf.wdata & regulator_cfg_pkg::reg_mask(rf.addr);
    end
    if (rf.addr < 8'(NUM_REGS)) begin
      next_rdata = regs[rf.addr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= regulator_cfg_pkg::reg_reset(8'(i));
      end
      rdata <= 8'h00;
    end else begin
      regs <= next_regs;
      rdata <= next_rdata;
    end
  end

  assign rf.rdata = rdata;
  assign rf.contents = regs;

endmodule : reg_store
`default_nettype wire

// ### regfile_if.sv
// Purpose: carries write, read and contents between serial port and store
// Assumes: one writer, one reader
// Notes: contents is the whole bank, flop outputs
`timescale 1ns/100ps
`default_nettype none
interface regfile_if #(parameter int NUM_REGS = 11, parameter int WIDTH = 8);
  logic wr_en;
  logic [7:0] addr;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] rdata;
  logic [NUM_REGS-1:0][WIDTH-1:0] contents;
  modport store (input wr_en, addr, wdata, output rdata, contents);
  modport user (output wr_en, addr, wdata, input rdata, contents);
endinterface : regfile_if
`default_nettype wire

// ### regulator_cfg_pkg.sv
// Purpose: shared constants for the regulator configuration register bank
// Assumes: byte-wide registers reached through an 8-bit sub-address
// Notes: reset values are masked to the used bits by reg_reset
package regulator_cfg_pkg;

  localparam int NUM_REGS = 11;
  localparam int NUM_CH = 3;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // sub-addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_VOUT_BASE = 8'h00;
  localparam logic [7:0] OFS_RAMP_BASE = 8'h03;
  localparam logic [7:0] OFS_CEIL_BASE = 8'h06;
  localparam logic [7:0] OFS_RATE = 8'h09;
  localparam logic [7:0] OFS_POWER = 8'h0A;

  // ----------------------------------------------------------------
  // factory defaults and used-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_VOUT = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'h15;
  localparam logic [7:0] RST_CEIL = 8'h05;
  localparam logic [7:0] RST_RATE = 8'h40;
  localparam logic [7:0] RST_POWER = 8'h7F;
  localparam logic [7:0] MASK_VOUT = 8'hFF;
  localparam logic [7:0] MASK_RAMP = 8'h77;
  localparam logic [7:0] MASK_CEIL = 8'h07;
  localparam logic [7:0] MASK_RATE = 8'h7F;
  localparam logic [7:0] MASK_POWER = 8'h4F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EXT_BIT = 7;
  localparam int DELAY_LSB = 4;
  localparam int PHASE_LSB = 5;
  localparam int PSKIP_BIT = 3;
  localparam int UV_BIT = 6;

  // ----------------------------------------------------------------
  // voltage code scale and serial address
  // ----------------------------------------------------------------
  localparam logic [12:0] VOUT_BASE_MV = 13'h0320;
  localparam logic [12:0] VOUT_STEP_MV = 13'h0032;
  localparam logic [6:0] VOUT_MAX_CODE = 7'h68;
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h3A;

  function automatic logic [7:0] reg_mask(input logic [7:0] idx);
    if (idx < OFS_RAMP_BASE) return MASK_VOUT;
    else if (idx < OFS_CEIL_BASE) return MASK_RAMP;
    else if (idx < OFS_RATE) return MASK_CEIL;
    else if (idx == OFS_RATE) return MASK_RATE;
    else if (idx == OFS_POWER) return MASK_POWER;
    else return 8'h00;
  endfunction : reg_mask

  function automatic logic [7:0] reg_reset(input logic [7:0] idx);
    logic [7:0] raw;
    if (idx < OFS_RAMP_BASE) raw = RST_VOUT;
    else if (idx < OFS_CEIL_BASE) raw = RST_RAMP;
    else if (idx < OFS_RATE) raw = RST_CEIL;
    else if (idx == OFS_RATE) raw = RST_RATE;
    else raw = RST_POWER;
    return raw & reg_mask(idx);
  endfunction : reg_reset

endpackage : regulator_cfg_pkg

// ### tb_triple_regulator_config_regs.sv
// Purpose: self-checking bench for the regulator configuration registers
// Assumes: host model on the serial port, sda pulled up on the wire
// Notes: expected values come from the register table written out here
`timescale 1ns/100ps
`default_nettype none
module tb_triple_regulator_config_regs;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic addr_sel = 1'b0;
  logic enable_pin = 1'b0;
  logic scl;
  logic host_low;
  logic sda_oe_n;
  logic sda_out;
  // pulled up: low only while the host pulls or the device drives its low level
  wire sda = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
  logic [2:0][6:0] vout_code;
  logic [2:0] ext_feedback_sel;
  logic [2:0][12:0] target_mv;
  logic [2:0][2:0] startup_delay_code;
  logic [2:0][2:0] ramp_time_code;
  logic [2:0][2:0] current_ceiling_code;
  logic [2:0] channel_enable;
  logic [1:0] phase_shift_sel;
  logic [4:0] switch_rate_code;
  logic pulse_skip_enable;
  logic input_undervoltage_sel;
  int num_errors = 0;
  int samples_checked = 0;
  logic ok;
  logic [7:0] wb [11];
  logic [7:0] rb [11];
  logic [7:0] exp_rst [11] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h15, 8'h15, 8'h05, 8'h05,
                               8'h05, 8'h40, 8'h4F};
  logic [7:0] exp_mask [11] = '{8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h77, 8'h77, 8'h07, 8'h07,
                                8'h07, 8'h7F, 8'h4F};

  initial begin
    forever #25 sys_clk = !sys_clk;
  end

  i2c_host_model u_host (.sys_clk(sys_clk), .scl(scl), .sda_low(host_low), .sda(sda));

  triple_regulator_config_regs u_dut (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .enable_pin(enable_pin),
    .vout_code(vout_code), .ext_feedback_sel(ext_feedback_sel), .target_mv(target_mv),
    .startup_delay_code(startup_delay_code), .ramp_time_code(ramp_time_code),
    .current_ceiling_code(current_ceiling_code), .channel_enable(channel_enable),
    .phase_shift_sel(phase_shift_sel), .switch_rate_code(switch_rate_code),
    .pulse_skip_enable(pulse_skip_enable), .input_undervoltage_sel(input_undervoltage_sel)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic write_one(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] v);
    wb[0] = v;
    u_host.write_regs(dev, sub, 1, wb, ok);
  endtask : write_one

  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    results;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("target reset", target_mv[0], 32'h320);
    check("enable reset", channel_enable, 32'h0);
    u_host.read_regs(8'hE8, 8'h00, 11, rb, ok);
    check("read ack", ok, 32'h1);
    for (int i = 0; i < 11; i++) check("reset value", rb[i], exp_rst[i]);
    check("ramp reset", ramp_time_code[0], 32'h5);
    check("delay reset", startup_delay_code[2], 32'h1);
    check("ceiling reset", current_ceiling_code[1], 32'h5);
    check("phase reset", phase_shift_sel, 32'h2);
    check("rate reset", switch_rate_code, 32'h0);
    check("skip reset", pulse_skip_enable, 32'h1);
    check("uv reset", input_undervoltage_sel, 32'h1);
    // all ones: unused bits drop, external feedback overrides the code
    for (int i = 0; i < 11; i++) wb[i] = 8'hFF;
    u_host.write_regs(8'hE8, 8'h00, 11, wb, ok);
    check("burst write ack", ok, 32'h1);
    u_host.read_regs(8'hE8, 8'h00, 11, rb, ok);
    for (int i = 0; i < 11; i++) check("masked value", rb[i], exp_mask[i]);
    check("ext flags", ext_feedback_sel, 32'h7);
    check("code ch2", vout_code[1], 32'h7F);
    for (int i = 0; i < 3; i++) check("ext target", target_mv[i], 32'h320);
    // per-channel codes, boundary at the top code
    wb[0] = 8'h00;
    wb[1] = 8'h68;
    wb[2] = 8'h23;
    u_host.write_regs(8'hE8, 8'h00, 3, wb, ok);
    repeat (2) @(posedge sys_clk);
    check("ext cleared", ext_feedback_sel, 32'h0);
    check("target ch1", target_mv[0], 32'h320);
    check("target ch2", target_mv[1], 32'h1770);
    check("target ch3", target_mv[2], 32'h9F6);
    check("code ch3", vout_code[2], 32'h23);
    write_one(8'hE8, 8'h00, 8'h7F);
    check("clamp ch1", target_mv[0], 32'h1770);
    u_host.read_regs(8'hE8, 8'h01, 1, rb, ok);
    check("sub select", rb[0], 32'h68);
    // field placement
    write_one(8'hE8, 8'h03, 8'h35);
    check("delay ch1", startup_delay_code[0], 32'h3);
    check("ramp ch1", ramp_time_code[0], 32'h5);
    write_one(8'hE8, 8'h09, 8'h4C);
    check("phase", phase_shift_sel, 32'h2);
    check("rate", switch_rate_code, 32'h0C);
    write_one(8'hE8, 8'h0A, 8'h32);
    check("skip off", pulse_skip_enable, 32'h0);
    check("uv off", input_undervoltage_sel, 32'h0);
    check("no enable before pin", channel_enable, 32'h0);
    @(posedge sys_clk);
    enable_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("enable on pin rise", channel_enable, 32'h2);
    enable_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("enable off", channel_enable, 32'h0);
    // wrong slave address is ignored
    write_one(8'hE4, 8'h03, 8'h00);
    check("wrong address nack", ok, 32'h0);
    check("ramp kept", ramp_time_code[0], 32'h5);
    // unmapped sub-address
    write_one(8'hE8, 8'h0B, 8'h5A);
    u_host.read_regs(8'hE8, 8'h0B, 1, rb, ok);
    check("unmapped read", rb[0], 32'h00);
    // strapped address bit, unused ceiling bits dropped
    @(posedge sys_clk);
    addr_sel <= 1'b1;
    write_one(8'hEA, 8'h06, 8'hFB);
    check("strap ack", ok, 32'h1);
    check("ceiling ch1", current_ceiling_code[0], 32'h3);
    results;
  end
endmodule : tb_triple_regulator_config_regs
`default_nettype wire

// ### triple_regulator_config_regs.sv
// Purpose: configuration registers of a three-channel step-down regulator
// Assumes: two-wire serial port sampled on sys_clk (20 MHz), far faster than scl
// Notes: sda is open drain; the pad resolves sda_oe_n low as a driven zero
`timescale 1ns/100ps
`default_nettype none
module triple_regulator_config_regs #(
  parameter int NUM_CH = regulator_cfg_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_sel,
  input wire logic enable_pin,
  output logic [NUM_CH-1:0][6:0] vout_code,
  output logic [NUM_CH-1:0] ext_feedback_sel,
  output logic [NUM_CH-1:0][12:0] target_mv,
  output logic [NUM_CH-1:0][2:0] startup_delay_code,
  output logic [NUM_CH-1:0][2:0] ramp_time_code,
  output logic [NUM_CH-1:0][2:0] current_ceiling_code,
  output logic [NUM_CH-1:0] channel_enable,
  output logic [1:0] phase_shift_sel,
  output logic [4:0] switch_rate_code,
  output logic pulse_skip_enable,
  output logic input_undervoltage_sel
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } link_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_SUB = 2'b01,
    PH_WR = 2'b10
  } byte_phase_t;

  if (NUM_CH != regulator_cfg_pkg::NUM_CH) begin : g_chk
    $error("triple_regulator_config_regs: the map holds exactly three channels");
  end

  regfile_if #(.NUM_REGS(regulator_cfg_pkg::NUM_REGS), .WIDTH(8)) rf ();

  reg_store #(.NUM_REGS(regulator_cfg_pkg::NUM_REGS)) u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .rf(rf)
  );

  // ----------------------------------------------------------------
  // line edge detection
  // ----------------------------------------------------------------
  logic scl_q, sda_q, en_q;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      en_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      en_q <= enable_pin;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  link_state_t state, next_state;
  byte_phase_t phase, next_phase;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] sub_addr, next_sub_addr;
  logic rw, next_rw;
  logic host_ack, next_host_ack;
  logic drive_low, next_drive_low;
  logic wr_en;

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_sub_addr = sub_addr;
    next_rw = rw;
    next_host_ack = host_ack;
    next_drive_low = drive_low;
    wr_en = 1'b0;
    if (start_seen) begin
      next_state = ST_RX;
      next_phase = PH_ADDR;
      next_bit_cnt = 4'h0;
      next_drive_low = 1'b0;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_drive_low = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_drive_low = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_in};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            next_state = ST_ACK;
            next_drive_low = 1'b1;
            unique case (phase)
              PH_ADDR: begin
                if (shift[7:1] == {regulator_cfg_pkg::SLAVE_ADDR_HI, addr_sel}) begin
                  next_rw = shift[0];
                end else begin
                  next_state = ST_IDLE;
                  next_drive_low = 1'b0;
                end
              end
              PH_SUB: next_sub_addr = shift;
              PH_WR: wr_en = 1'b1;
              default: next_state = ST_IDLE;
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_bit_cnt = 4'h0;
            if (phase == PH_ADDR && rw) begin
              next_state = ST_TX;
              next_shift = rf.rdata;
              next_drive_low = ~rf.rdata[7];
            end else begin
              next_state = ST_RX;
              next_phase = (phase == PH_ADDR) ? PH_SUB : PH_WR;
              if (phase == PH_WR) begin
                next_sub_addr = sub_addr + 8'h01;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_state = ST_MACK;
              next_drive_low = 1'b0;
              next_sub_addr = sub_addr + 8'h01;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_drive_low = ~shift[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_host_ack = ~sda_in;
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (host_ack) begin
              next_state = ST_TX;
              next_shift = rf.rdata;
              next_drive_low = ~rf.rdata[7];
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      sub_addr <= 8'h00;
      rw <= 1'b0;
      host_ack <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      sub_addr <= next_sub_addr;
      rw <= next_rw;
      host_ack <= next_host_ack;
      drive_low <= next_drive_low;
    end
  end

  assign rf.wr_en = wr_en;
  assign rf.addr = sub_addr;
  assign rf.wdata = shift;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low;

  // ----------------------------------------------------------------
  // field decode and channel enables
  // ----------------------------------------------------------------
  logic [7:0] rate_reg, power_reg;
  logic [NUM_CH-1:0][12:0] next_target_mv;
  logic [NUM_CH-1:0] next_channel_enable;

  assign rate_reg = rf.contents[regulator_cfg_pkg::OFS_RATE];
  assign power_reg = rf.contents[regulator_cfg_pkg::OFS_POWER];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [7:0] vreg, rreg, lreg;
    logic [6:0] code_lim;
    assign vreg = rf.contents[regulator_cfg_pkg::OFS_VOUT_BASE + c];
    assign rreg = rf.contents[regulator_cfg_pkg::OFS_RAMP_BASE + c];
    assign lreg = rf.contents[regulator_cfg_pkg::OFS_CEIL_BASE + c];
    assign vout_code[c] = vreg[6:0];
    assign ext_feedback_sel[c] = vreg[regulator_cfg_pkg::EXT_BIT];
    assign startup_delay_code[c] = rreg[regulator_cfg_pkg::DELAY_LSB +: 3];
    assign ramp_time_code[c] = rreg[2:0];
    assign current_ceiling_code[c] = lreg[2:0];
    // codes past the top step hold the highest setting
    assign code_lim = (vreg[6:0] > regulator_cfg_pkg::VOUT_MAX_CODE) ?
                      regulator_cfg_pkg::VOUT_MAX_CODE : vreg[6:0];
    always_comb begin
      if (vreg[regulator_cfg_pkg::EXT_BIT]) begin
        next_target_mv[c] = regulator_cfg_pkg::VOUT_BASE_MV;
      end else begin
        next_target_mv[c] = 13'(regulator_cfg_pkg::VOUT_BASE_MV +
                            regulator_cfg_pkg::VOUT_STEP_MV * 13'(code_lim));
      end
      if (!enable_pin) begin
        next_channel_enable[c] = 1'b0;
      end else if (!en_q) begin
        next_channel_enable[c] = power_reg[c];
      end else begin
        next_channel_enable[c] = channel_enable[c];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      target_mv <= '0;
      channel_enable <= '0;
    end else begin
      target_mv <= next_target_mv;
      channel_enable <= next_channel_enable;
    end
  end

  assign phase_shift_sel = rate_reg[regulator_cfg_pkg::PHASE_LSB +: 2];
  assign switch_rate_code = rate_reg[4:0];
  assign pulse_skip_enable = power_reg[regulator_cfg_pkg::PSKIP_BIT];
  assign input_undervoltage_sel = power_reg[regulator_cfg_pkg::UV_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_vout_write;
    (rf.wr_en && rf.addr == regulator_cfg_pkg::OFS_VOUT_BASE) |=>
      vout_code[0] == $past(rf.wdata[6:0]) && ext_feedback_sel[0] == $past(rf.wdata[7]);
  endproperty
  a_vout_write: assert property (p_vout_write) else $error("voltage write lost");

  property p_target_scale;
    (!ext_feedback_sel[1] && vout_code[1] <= regulator_cfg_pkg::VOUT_MAX_CODE) |=>
      target_mv[1] == 13'(13'h0320 + 13'h0032 * 13'($past(vout_code[1])));
  endproperty
  a_target_scale: assert property (p_target_scale) else $error("target scale wrong");

  property p_ext_override;
    ext_feedback_sel[2] |=> target_mv[2] == regulator_cfg_pkg::VOUT_BASE_MV;
  endproperty
  a_ext_override: assert property (p_ext_override) else $error("code not ignored");

  property p_vout_default;
    $fell(rst) |-> vout_code == '0 && ext_feedback_sel == '0;
  endproperty
  a_vout_default: assert property (@(posedge sys_clk) p_vout_default)
    else $error("voltage default wrong");

  property p_ch3_only;
    (rf.wr_en && rf.addr == 8'h02) |=> $stable(vout_code[0]) && $stable(vout_code[1]);
  endproperty
  a_ch3_only: assert property (p_ch3_only) else $error("wrong channel written");

  property p_ramp_default;
    $fell(rst) |-> startup_delay_code[0] == 3'h1 && ramp_time_code[2] == 3'h5;
  endproperty
  a_ramp_default: assert property (@(posedge sys_clk) p_ramp_default)
    else $error("ramp default wrong");

  property p_rate_default;
    $fell(rst) |-> phase_shift_sel == 2'h2 && switch_rate_code == 5'h00;
  endproperty
  a_rate_default: assert property (@(posedge sys_clk) p_rate_default)
    else $error("rate default wrong");

  property p_ceil_write;
    (rf.wr_en && rf.addr == regulator_cfg_pkg::OFS_CEIL_BASE) |=>
      current_ceiling_code[0] == $past(rf.wdata[2:0]) && rf.contents[6][7:3] == 5'h00;
  endproperty
  a_ceil_write: assert property (p_ceil_write) else $error("limit write wrong");

  property p_enable_edge;
    $rose(enable_pin) |=> channel_enable == $past(power_reg[2:0]) ##1 $stable(channel_enable)
      or !enable_pin;
  endproperty
  a_enable_edge: assert property (p_enable_edge) else $error("enable edge wrong");

  property p_enable_low;
    !enable_pin |=> channel_enable == '0;
  endproperty
  a_enable_low: assert property (p_enable_low) else $error("enable not cleared");

  property p_sub_take;
    (state == ST_RX && phase == PH_SUB && scl_fall && bit_cnt == 4'h8 && !start_seen
      && !stop_seen) |=> sub_addr == $past(shift) && state == ST_ACK && drive_low;
  endproperty
  a_sub_take: assert property (p_sub_take) else $error("sub-address not taken");

  property p_unused_zero;
    (rf.addr == regulator_cfg_pkg::OFS_POWER) |=> (rf.rdata & 8'hB0) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit reads one");

  c_write: cover property (rf.wr_en && rf.addr == regulator_cfg_pkg::OFS_POWER);
  c_read_byte: cover property (state == ST_TX ##[1:1000] state == ST_MACK);
  c_enable: cover property ($rose(enable_pin) ##1 channel_enable != '0);
  c_host_nack: cover property (state == ST_MACK && scl_fall && !host_ack);

endmodule : triple_regulator_config_regs
`default_nettype wire
